// ===== include/blsm_pkg.sv
`default_nettype none
package blsm_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TICK_W = 16;
   localparam int unsigned MS_W = 19;
   localparam int unsigned ENTRY_S = 5;
   localparam int unsigned ENTRY_MS = ENTRY_S * 1000;
   localparam int unsigned LONG_S = 3;
   localparam int unsigned LONG_MS = LONG_S * 1000;
   localparam int unsigned TIMEOUT_MIN = 5;
   localparam int unsigned TIMEOUT_MS = TIMEOUT_MIN * 60 * 1000;
   localparam int unsigned DEB_MS = 20;
   localparam int unsigned BLINK_MS = 500;
   localparam int unsigned SHOW_MS = 1000;
   localparam int unsigned SWEEP_MS = 250;
   localparam int unsigned LED_N = 5;
   localparam int unsigned LED_V12 = 0;
   localparam int unsigned LED_V24 = 1;
   localparam int unsigned LED_CFG = 2;
   localparam int unsigned LED_BUS = 3;
   localparam int unsigned LED_ACT = 4;
   localparam logic [1:0] SEL_COMM = 2'h0;
   localparam logic [1:0] SEL_FACT = 2'h1;
   localparam logic [1:0] SEL_VOLT = 2'h2;
   localparam logic [1:0] SEL_LAST = 2'h2;
   typedef enum logic [2:0] {
      ST_SETTLE, ST_PWRUP, ST_MENU, ST_CONFIRM, ST_VSEL, ST_SWEEP, ST_RUN
   } blsm_state_t;
endpackage
`default_nettype wire

// ===== core/blsm_button.sv
`default_nettype none
module blsm_button #(
   parameter int unsigned DEB_MS = blsm_pkg::DEB_MS,
   parameter int unsigned LONG_MS = blsm_pkg::LONG_MS,
   parameter int unsigned CW = blsm_pkg::MS_W
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic btn_b,
   input wire logic tick,
   output logic lvl,
   output logic short_p,
   output logic long_p
);
   localparam logic [CW-1:0] DEB_L = CW'(DEB_MS - 1);
   localparam logic [CW-1:0] LONG_L = CW'(LONG_MS - 1);
   logic s1_r, s2_r, lvl_r, lvl_nxt, done_r, done_nxt, sp_r, sp_nxt, lp_r, lp_nxt;
   logic [CW-1:0] deb_r, deb_nxt, hold_r, hold_nxt;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= 1'h1;
         s2_r <= 1'h1;
      end
      else
      begin
         s1_r <= btn_b;
         s2_r <= s1_r;
      end
   end

   // Debounce, then tell a short press from a long hold.
   always_comb
   begin
      lvl_nxt = lvl_r;
      deb_nxt = deb_r;
      hold_nxt = hold_r;
      done_nxt = done_r;
      sp_nxt = 1'h0;
      lp_nxt = 1'h0;
      if (!s2_r == lvl_r)
         deb_nxt = '0;
      else if (tick)
      begin
         if (deb_r == DEB_L)
         begin
            lvl_nxt = !s2_r;
            deb_nxt = '0;
         end
         else
            deb_nxt = deb_r + CW'(1);
      end
      if (!lvl_r)
      begin
         hold_nxt = '0;
         done_nxt = 1'h0;
      end
      else if (tick && !done_r)
      begin
         if (hold_r == LONG_L)
         begin
            lp_nxt = 1'h1;
            done_nxt = 1'h1;
         end
         else
            hold_nxt = hold_r + CW'(1);
      end
      if (lvl_r && !lvl_nxt && !done_r)
         sp_nxt = 1'h1;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_r <= 1'h0;
         deb_r <= '0;
         hold_r <= '0;
         done_r <= 1'h0;
         sp_r <= 1'h0;
         lp_r <= 1'h0;
      end
      else
      begin
         lvl_r <= lvl_nxt;
         deb_r <= deb_nxt;
         hold_r <= hold_nxt;
         done_r <= done_nxt;
         sp_r <= sp_nxt;
         lp_r <= lp_nxt;
      end
   end

   assign lvl = lvl_r;
   assign short_p = sp_r;
   assign long_p = lp_r;
endmodule
`default_nettype wire

// ===== core/blsm_menu.sv
`default_nettype none
// Operation
// - Battery path and load output stay off throughout setup mode.
// - Enter setup only after a 5 s hold from power-up; all LEDs lit meanwhile.
// - After the hold, LEDs go dark, then the first entry blinks.
// - On entry the fieldbus and output-active LEDs blink.
// - A short press advances to the next entry, wrapping after the last.
// - A 3 s hold confirms the entry; its LEDs then light steadily.
// - Confirming entry 3 or 4 leaves setup with a sequential LED sweep.
// - Confirming entry 5 stays in setup and shows the stored rating.
// - In voltage selection a short press toggles 24 V and 12 V; 24 V default.
// - A 3 s hold stores the shown rating, then exits with the sweep.
// - The load is enabled only after the exit sweep has finished.
// - Five idle minutes exit setup unchanged and start the load.
// - Entry 3 restores communication defaults; fieldbus and active LEDs blink.
// - Entry 4 restores factory state, forcing 24 V; only one LED blinks.
// - Entry 5 selects voltage; configuration and active LEDs blink.
module blsm_menu #(
   parameter int unsigned TICK_CYC = blsm_pkg::TICK_CYC,
   parameter int unsigned ENTRY_MS = blsm_pkg::ENTRY_MS,
   parameter int unsigned LONG_MS = blsm_pkg::LONG_MS,
   parameter int unsigned TIMEOUT_MS = blsm_pkg::TIMEOUT_MS,
   parameter int unsigned DEB_MS = blsm_pkg::DEB_MS,
   parameter int unsigned CW = blsm_pkg::MS_W
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic btn_b,
   input wire logic nvm_v12_in,
   output logic [blsm_pkg::LED_N-1:0] led,
   output logic batt_en,
   output logic load_en,
   output logic setup_active,
   output logic rating_v12,
   output logic nvm_wr,
   output logic comm_dflt,
   output logic factory_rst
);
   localparam int unsigned LN = blsm_pkg::LED_N;
   localparam int unsigned TW = blsm_pkg::TICK_W;
   localparam logic [TW-1:0] TICK_L = TW'(TICK_CYC - 1);
   localparam logic [CW-1:0] DEB_L = CW'(DEB_MS);
   localparam logic [CW-1:0] ENTRY_L = CW'(ENTRY_MS - 1);
   localparam logic [CW-1:0] TOUT_L = CW'(TIMEOUT_MS - 1);
   localparam logic [CW-1:0] BLINK_L = CW'(blsm_pkg::BLINK_MS - 1);
   localparam logic [CW-1:0] SHOW_L = CW'(blsm_pkg::SHOW_MS - 1);
   localparam logic [CW-1:0] SWEEP_L = CW'(blsm_pkg::SWEEP_MS - 1);
   localparam logic [2:0] SWEEP_END = 3'(LN - 1);

   blsm_pkg::blsm_state_t st_r, st_nxt;
   logic [TW-1:0] div_r, div_nxt;
   logic tick_r, tick_nxt;
   logic [CW-1:0] ms_r, ms_nxt, idle_r, idle_nxt, blk_r, blk_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic [2:0] sweep_r, sweep_nxt;
   logic v12_r, v12_nxt, vshow_r, vshow_nxt, phase_r, phase_nxt;
   logic [LN-1:0] led_r, led_nxt;
   logic batt_r, load_r, setup_r, wr_r, wr_nxt, comm_r, comm_nxt, fact_r, fact_nxt;
   logic lvl, short_p, long_p, idle_out;

   // Steady LED picture of each menu entry.
   function automatic logic [LN-1:0] menu_pat(input logic [1:0] sel);
      logic [LN-1:0] p;
      p = '0;
      if (sel == blsm_pkg::SEL_COMM)
      begin
         p[blsm_pkg::LED_BUS] = 1'h1;
         p[blsm_pkg::LED_ACT] = 1'h1;
      end
      else if (sel == blsm_pkg::SEL_FACT)
         p[blsm_pkg::LED_CFG] = 1'h1;
      else
      begin
         p[blsm_pkg::LED_CFG] = 1'h1;
         p[blsm_pkg::LED_ACT] = 1'h1;
      end
      return p;
   endfunction

   // Steady LED picture of a voltage rating.
   function automatic logic [LN-1:0] volt_pat(input logic v12);
      logic [LN-1:0] p;
      p = '0;
      p[blsm_pkg::LED_CFG] = 1'h1;
      p[blsm_pkg::LED_ACT] = 1'h1;
      if (v12)
         p[blsm_pkg::LED_V12] = 1'h1;
      else
         p[blsm_pkg::LED_V24] = 1'h1;
      return p;
   endfunction

   blsm_button #(.DEB_MS(DEB_MS), .LONG_MS(LONG_MS), .CW(CW)) u_btn (
      .clk(clk),
      .rst_b(rst_b),
      .btn_b(btn_b),
      .tick(tick_r),
      .lvl(lvl),
      .short_p(short_p),
      .long_p(long_p)
   );

   // Millisecond enable and blink phase.
   always_comb
   begin
      div_nxt = (div_r == TICK_L) ? '0 : div_r + TW'(1);
      tick_nxt = (div_r == TICK_L);
      blk_nxt = blk_r;
      phase_nxt = phase_r;
      if (st_nxt != st_r)
      begin
         blk_nxt = '0;
         phase_nxt = 1'h0;
      end
      else if (tick_r)
      begin
         blk_nxt = (blk_r == BLINK_L) ? '0 : blk_r + CW'(1);
         if (blk_r == BLINK_L)
            phase_nxt = !phase_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_r <= '0;
         tick_r <= 1'h0;
         blk_r <= '0;
         phase_r <= 1'h0;
      end
      else
      begin
         div_r <= div_nxt;
         tick_r <= tick_nxt;
         blk_r <= blk_nxt;
         phase_r <= phase_nxt;
      end
   end

   // Compares with at-least so that idle time spent in confirm cannot step past the limit.
   assign idle_out = tick_r && idle_r >= TOUT_L && !lvl;

   // Menu sequencer.
   always_comb
   begin
      st_nxt = st_r;
      ms_nxt = tick_r ? ms_r + CW'(1) : ms_r;
      idle_nxt = (lvl || st_r == blsm_pkg::ST_RUN) ? '0 : (tick_r ? idle_r + CW'(1) : idle_r);
      sel_nxt = sel_r;
      sweep_nxt = sweep_r;
      v12_nxt = v12_r;
      vshow_nxt = vshow_r;
      wr_nxt = 1'h0;
      comm_nxt = 1'h0;
      fact_nxt = 1'h0;
      case (st_r)
         blsm_pkg::ST_SETTLE:
            if (tick_r && ms_r == DEB_L)
            begin
               v12_nxt = nvm_v12_in;
               ms_nxt = '0;
               st_nxt = lvl ? blsm_pkg::ST_PWRUP : blsm_pkg::ST_RUN;
            end
         blsm_pkg::ST_PWRUP:
            if (!lvl)
               st_nxt = blsm_pkg::ST_RUN;
            else if (tick_r && ms_r == ENTRY_L)
            begin
               st_nxt = blsm_pkg::ST_MENU;
               sel_nxt = blsm_pkg::SEL_COMM;
               ms_nxt = '0;
            end
         blsm_pkg::ST_MENU:
            if (idle_out)
               st_nxt = blsm_pkg::ST_RUN;
            else if (short_p)
               sel_nxt = (sel_r == blsm_pkg::SEL_LAST) ? blsm_pkg::SEL_COMM : sel_r + 2'h1;
            else if (long_p)
            begin
               st_nxt = blsm_pkg::ST_CONFIRM;
               ms_nxt = '0;
               if (sel_r == blsm_pkg::SEL_COMM)
                  comm_nxt = 1'h1;
               else if (sel_r == blsm_pkg::SEL_FACT)
               begin
                  fact_nxt = 1'h1;
                  v12_nxt = 1'h0;
                  wr_nxt = 1'h1;
               end
            end
         blsm_pkg::ST_CONFIRM:
            if (tick_r && ms_r == SHOW_L)
            begin
               ms_nxt = '0;
               sweep_nxt = '0;
               vshow_nxt = v12_r;
               st_nxt = (sel_r == blsm_pkg::SEL_VOLT) ? blsm_pkg::ST_VSEL : blsm_pkg::ST_SWEEP;
            end
         blsm_pkg::ST_VSEL:
            if (idle_out)
               st_nxt = blsm_pkg::ST_RUN;
            else if (short_p)
               vshow_nxt = !vshow_r;
            else if (long_p)
            begin
               v12_nxt = vshow_r;
               wr_nxt = 1'h1;
               ms_nxt = '0;
               sweep_nxt = '0;
               st_nxt = blsm_pkg::ST_SWEEP;
            end
         blsm_pkg::ST_SWEEP:
            if (tick_r && ms_r == SWEEP_L)
            begin
               ms_nxt = '0;
               if (sweep_r == SWEEP_END)
                  st_nxt = blsm_pkg::ST_RUN;
               else
                  sweep_nxt = sweep_r + 3'h1;
            end
         default:
            ms_nxt = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= blsm_pkg::ST_SETTLE;
         ms_r <= '0;
         idle_r <= '0;
         sel_r <= blsm_pkg::SEL_COMM;
         sweep_r <= '0;
         v12_r <= 1'h0;
         vshow_r <= 1'h0;
         wr_r <= 1'h0;
         comm_r <= 1'h0;
         fact_r <= 1'h0;
      end
      else
      begin
         st_r <= st_nxt;
         ms_r <= ms_nxt;
         idle_r <= idle_nxt;
         sel_r <= sel_nxt;
         sweep_r <= sweep_nxt;
         v12_r <= v12_nxt;
         vshow_r <= vshow_nxt;
         wr_r <= wr_nxt;
         comm_r <= comm_nxt;
         fact_r <= fact_nxt;
      end
   end

   // LED picture and power path enables.
   always_comb
   begin
      case (st_r)
         blsm_pkg::ST_SETTLE, blsm_pkg::ST_PWRUP:
            led_nxt = '1;
         blsm_pkg::ST_MENU:
            led_nxt = phase_r ? menu_pat(sel_r) : '0;
         blsm_pkg::ST_CONFIRM:
            led_nxt = menu_pat(sel_r);
         blsm_pkg::ST_VSEL:
            led_nxt = phase_r ? volt_pat(vshow_r) : '0;
         blsm_pkg::ST_SWEEP:
            led_nxt = LN'(1) << sweep_r;
         default:
            led_nxt = LN'(1) << blsm_pkg::LED_ACT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         led_r <= '0;
         batt_r <= 1'h0;
         load_r <= 1'h0;
         setup_r <= 1'h0;
      end
      else
      begin
         led_r <= led_nxt;
         batt_r <= (st_r == blsm_pkg::ST_RUN);
         load_r <= (st_r == blsm_pkg::ST_RUN);
         setup_r <= (st_r != blsm_pkg::ST_RUN) && (st_r != blsm_pkg::ST_SETTLE);
      end
   end

   assign led = led_r;
   assign batt_en = batt_r;
   assign load_en = load_r;
   assign setup_active = setup_r;
   assign rating_v12 = v12_r;
   assign nvm_wr = wr_r;
   assign comm_dflt = comm_r;
   assign factory_rst = fact_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   a_setup_power_off: assert property (setup_r |-> !load_r && !batt_r)
      else $error("Power path enabled during setup.");
   a_hold_leds_lit: assert property (st_r == blsm_pkg::ST_PWRUP |=> led_r == '1)
      else $error("LEDs not all lit during power-up hold.");
   a_entry_after_hold: assert property (st_r == blsm_pkg::ST_PWRUP && lvl && tick_r
      && ms_r == ENTRY_L |=> st_r == blsm_pkg::ST_MENU && sel_r == blsm_pkg::SEL_COMM ##1 led_r == '0)
      else $error("Menu not entered dark on first entry.");
   a_release_skip: assert property (st_r == blsm_pkg::ST_PWRUP && !lvl |=> st_r == blsm_pkg::ST_RUN ##1 load_r)
      else $error("Early release did not start normally.");
   a_short_advance: assert property (st_r == blsm_pkg::ST_MENU && short_p && !idle_out
      |=> sel_r == (($past(sel_r) == blsm_pkg::SEL_LAST) ? blsm_pkg::SEL_COMM : $past(sel_r) + 2'h1))
      else $error("Short press did not advance the entry.");
   a_confirm_steady: assert property (st_r == blsm_pkg::ST_CONFIRM |=> led_r == menu_pat(sel_r))
      else $error("Confirmed entry not shown steady.");
   a_vsel_toggle: assert property (st_r == blsm_pkg::ST_VSEL && short_p && !idle_out
      |=> vshow_r != $past(vshow_r))
      else $error("Short press did not toggle the rating.");
   a_vsel_store: assert property (st_r == blsm_pkg::ST_VSEL && long_p && !idle_out
      |=> wr_r && v12_r == $past(vshow_r) && st_r == blsm_pkg::ST_SWEEP)
      else $error("Rating not stored on long hold.");
   a_factory_24v: assert property (fact_r |-> wr_r && !v12_r)
      else $error("Factory restore did not force 24 V.");
   a_load_after_sweep: assert property (st_r == blsm_pkg::ST_SWEEP |=> !load_r)
      else $error("Load enabled before the sweep finished.");
   a_idle_exit: assert property ((st_r == blsm_pkg::ST_MENU || st_r == blsm_pkg::ST_VSEL)
      && idle_out |=> st_r == blsm_pkg::ST_RUN && !wr_r && v12_r == $past(v12_r))
      else $error("Idle timeout exit misbehaved.");
   a_menu_exit_sweep: assert property (st_r == blsm_pkg::ST_CONFIRM && sel_r != blsm_pkg::SEL_VOLT
      && tick_r && ms_r == SHOW_L |=> st_r == blsm_pkg::ST_SWEEP)
      else $error("Entry confirm did not start the sweep.");

   c_menu_entered: cover property (st_r == blsm_pkg::ST_PWRUP ##1 st_r == blsm_pkg::ST_MENU);
   c_volt_stored: cover property (st_r == blsm_pkg::ST_VSEL && long_p);
   c_idle_exit: cover property (st_r == blsm_pkg::ST_MENU && idle_out);
   c_sweep_done: cover property (st_r == blsm_pkg::ST_SWEEP ##1 st_r == blsm_pkg::ST_RUN);
endmodule
`default_nettype wire

// ===== test/blsm_operator.sv
`default_nettype none
// Models the operator at the start button; the button line idles high when released.
module blsm_operator #(
   parameter int unsigned TC = 4
)(
   input wire logic clk,
   output logic btn_b
);
   timeunit 1ns;
   timeprecision 1ps;

   initial btn_b = 1'b1;

   task automatic hold_btn();
      @(posedge clk);
      btn_b <= 1'b0;
   endtask

   task automatic release_btn();
      @(posedge clk);
      btn_b <= 1'b1;
   endtask

   // Presses for the given ticks, then waits for the release to settle.
   task automatic press(input int ticks);
      hold_btn();
      repeat (ticks * TC) @(posedge clk);
      btn_b <= 1'b1;
      repeat (5 * TC) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 4;
   localparam int TO_MS = 3000;
   logic clk;
   logic rst_b;
   wire logic btn_b;
   logic nvm_v12_in;
   logic [blsm_pkg::LED_N-1:0] led;
   logic batt_en;
   logic load_en;
   logic setup_active;
   logic rating_v12;
   logic nvm_wr;
   logic comm_dflt;
   logic factory_rst;
   int fail_count = 0;
   int comparisons = 0;
   int n_comm = 0;
   int n_fact = 0;
   int n_wr = 0;
   logic wr_rating = 1'b1;

   blsm_operator op (
      .clk(clk),
      .btn_b(btn_b)
   );

   blsm_menu #(
      .TICK_CYC(TC),
      .ENTRY_MS(20),
      .LONG_MS(10),
      .TIMEOUT_MS(TO_MS),
      .DEB_MS(2)
   ) uut (
      .clk(clk),
      .rst_b(rst_b),
      .btn_b(btn_b),
      .nvm_v12_in(nvm_v12_in),
      .led(led),
      .batt_en(batt_en),
      .load_en(load_en),
      .setup_active(setup_active),
      .rating_v12(rating_v12),
      .nvm_wr(nvm_wr),
      .comm_dflt(comm_dflt),
      .factory_rst(factory_rst)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Counts action pulses and watches that power stays off during setup.
   always @(negedge clk)
   begin
      if (comm_dflt === 1'b1) n_comm++;
      if (factory_rst === 1'b1) n_fact++;
      if (nvm_wr === 1'b1)
      begin
         n_wr++;
         wr_rating = rating_v12;
      end
      if (setup_active === 1'b1 && (batt_en !== 1'b0 || load_en !== 1'b0))
      begin
         $display("BAD power in setup expected 0 seen %b", {batt_en, load_en});
         fail_count++;
      end
   end

   task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic ticks(input int n);
      repeat (n * TC) @(negedge clk);
   endtask

   task automatic wait_led(input logic [4:0] v, input int lim);
      int i;
      i = 0;
      while (led !== v && i < lim * TC)
      begin
         @(negedge clk);
         i++;
      end
      chk("led reached", v, led);
   endtask

   // Watches the LEDs: only the pattern or dark when blinking, only the pattern when steady.
   task automatic chk_leds(input string what, input logic [4:0] pat, input bit steady);
      bit ok;
      bit seen;
      int i;
      ok = 1;
      seen = 0;
      for (i = 0; i < 600 * TC; i++)
      begin
         @(negedge clk);
         if (led === pat) seen = 1;
         else if (steady || led !== 5'h00) ok = 0;
      end
      chk(what, pat, (ok && seen) ? pat : led);
   endtask

   task automatic power_up(input logic v12);
      @(posedge clk);
      rst_b <= 1'b0;
      nvm_v12_in <= v12;
      op.hold_btn();
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      ticks(10);
      chk("leds during hold", 5'h1f, led);
   endtask

   task automatic enter_setup(input logic v12);
      power_up(v12);
      wait_led(5'h00, 40);
      op.release_btn();
      chk_leds("first entry", 5'h18, 0);
   endtask

   task automatic chk_sweep_run(input logic v12);
      int k;
      int i;
      for (k = 0; k < 5; k++) wait_led(5'h01 << k, (k == 0) ? 1200 : 300);
      i = 0;
      while (load_en !== 1'b1 && i < 300 * TC)
      begin
         @(negedge clk);
         i++;
      end
      chk("last sweep step", 5'h01, {4'h0, i > (blsm_pkg::SWEEP_MS - 10) * TC});
      wait_led(5'h10, 300);
      ticks(1);
      chk("load after sweep", 5'h03, {setup_active, batt_en, load_en});
      chk("run rating", {4'h0, v12}, {4'h0, rating_v12});
   endtask

   task automatic t_normal_start();
      power_up(1'b1);
      op.release_btn();
      ticks(30);
      chk("normal start", 5'h03, {setup_active, batt_en, load_en});
      chk("normal rating", 5'h01, {4'h0, rating_v12});
      $display("test normal_start done");
   endtask

   task automatic t_comm_restore();
      int c;
      enter_setup(1'b0);
      op.press(5);
      chk_leds("entry 4", 5'h04, 0);
      op.press(5);
      chk_leds("entry 5", 5'h14, 0);
      op.press(5);
      chk_leds("wrapped entry", 5'h18, 0);
      c = n_comm;
      op.press(15);
      chk_leds("entry 3 steady", 5'h18, 1);
      chk("comm pulse", 5'h01, 5'(n_comm - c));
      chk_sweep_run(1'b0);
      $display("test comm_restore done");
   endtask

   task automatic t_factory();
      int f;
      int w;
      enter_setup(1'b1);
      op.press(5);
      f = n_fact;
      w = n_wr;
      op.press(15);
      chk_leds("entry 4 steady", 5'h04, 1);
      chk("factory pulses", 5'h03, {3'h0, 1'(n_fact - f), 1'(n_wr - w)});
      chk("factory rating", 5'h00, {4'h0, wr_rating});
      chk_sweep_run(1'b0);
      $display("test factory done");
   endtask

   task automatic t_voltage();
      int w;
      enter_setup(1'b1);
      op.press(5);
      op.press(5);
      op.press(15);
      chk_leds("entry 5 steady", 5'h14, 1);
      wait_led(5'h15, 1200);
      chk_leds("stored 12V", 5'h15, 0);
      op.press(5);
      chk_leds("toggled 24V", 5'h16, 0);
      op.press(5);
      chk_leds("toggled 12V", 5'h15, 0);
      op.press(5);
      w = n_wr;
      op.press(15);
      chk("store pulse", 5'h01, 5'(n_wr - w));
      chk("stored rating", 5'h00, {4'h0, wr_rating});
      chk_sweep_run(1'b0);
      $display("test voltage done");
   endtask

   task automatic t_timeout();
      int c;
      c = n_comm + n_fact + n_wr;
      enter_setup(1'b1);
      op.press(5);
      ticks(TO_MS - 100);
      chk("idle not yet", 5'h02, {setup_active, load_en});
      ticks(200);
      chk("idle exit", 5'h01, {setup_active, load_en});
      chk("idle unchanged", 5'h01, {4'h0, rating_v12});
      chk("idle no actions", 5'h00, 5'(n_comm + n_fact + n_wr - c));
      $display("test timeout done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      rst_b = 1'b0;
      nvm_v12_in = 1'b0;
      repeat (10) @(posedge clk);
      t_normal_start();
      t_comm_restore();
      t_factory();
      t_voltage();
      t_timeout();
      final_report();
   end

   initial
   begin
      repeat (90000) @(posedge clk);
      $display("BAD watchdog expected done seen hang");
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
